// file: hdl/remote_capability_register.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"

module remote_capability_register
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_secondary,
    input wire logic i_second_port_select,
    input wire logic i_secondary_address_enable,
    input wire logic [1:0] i_rx_lock,
    input wire logic [1:0] i_auto_valid,
    input wire logic [1:0][6:0] i_auto_cap1,
    input wire logic [1:0][1:0] i_auto_cap2,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_ack,
    output logic [1:0] o_capability_freeze,
    output logic [1:0] o_frequency_training_request,
    output logic [1:0] o_equalizer_training_request,
    output logic [1:0] o_remote_two_link_support,
    output logic [1:0] o_secondary_channel,
    output logic [1:0][2:0] o_fast_control_channel_mode,
    output rcr_pkg::rcr_mode_t o_mode_port0,
    output rcr_pkg::rcr_mode_t o_mode_port1
);

    function automatic rcr_pkg::rcr_mode_t decode_mode(input logic [2:0] code);
        rcr_pkg::rcr_mode_t m;
        m = rcr_pkg::RCR_MODE_RESERVED;
        case (code)
            `RCR_CODE_NORMAL: m = rcr_pkg::RCR_MODE_NORMAL;
            `RCR_CODE_GPIO1: m = rcr_pkg::RCR_MODE_GPIO1;
            `RCR_CODE_GPIO2: m = rcr_pkg::RCR_MODE_GPIO2;
            `RCR_CODE_GPIO4: m = rcr_pkg::RCR_MODE_GPIO4;
            `RCR_CODE_SPI_FWD: m = rcr_pkg::RCR_MODE_SPI_FWD;
            `RCR_CODE_SPI_REV: m = rcr_pkg::RCR_MODE_SPI_REV;
            default: m = rcr_pkg::RCR_MODE_RESERVED;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] mode_code(input logic [7:0] c1, input logic [1:0] c2);
        return {c2, c1[`RCR_BIT_MODE_LO]};
    endfunction

    rcr_cap_if cap_if[2] ();

    logic access_ok;
    logic port_sel;
    logic hit_cap1;
    logic hit_cap2;
    logic [1:0][7:0] cap1_v;
    logic [1:0][1:0] cap2_v;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic ack_q;
    rcr_pkg::rcr_mode_t mode0_q;
    rcr_pkg::rcr_mode_t mode1_q;

    // Secondary-address traffic is only honoured once that address is enabled;
    // it always lands on Port1. Primary traffic follows the select bit unless the
    // secondary address is enabled, in which case the primary address stays on Port0.
    assign access_ok = !i_reg_secondary || i_secondary_address_enable;
    assign port_sel = i_reg_secondary ? `RCR_PORT1 :
                      (i_secondary_address_enable ? `RCR_PORT0 : i_second_port_select); // R06 R12
    assign hit_cap1 = access_ok && (i_reg_addr == `RCR_ADDR_CAP1);
    assign hit_cap2 = access_ok && (i_reg_addr == `RCR_ADDR_CAP2);

    for (genvar p = 0; p < 2; p++)
    begin : g_port
        // Software that overwrites fields must set freeze too, otherwise the next
        // locked update replaces them; the store does not guard against that.
        assign cap_if[p].host_wr1 = i_reg_wr && hit_cap1 && (port_sel == 1'(p)); // R06
        assign cap_if[p].host_wr2 = i_reg_wr && hit_cap2 && (port_sel == 1'(p)); // R06
        assign cap_if[p].wdata = i_reg_wdata;
        assign cap_if[p].auto_ld = i_auto_valid[p] && i_rx_lock[p]; // R04
        assign cap_if[p].auto_cap1 = i_auto_cap1[p];
        assign cap_if[p].auto_cap2 = i_auto_cap2[p];
        assign cap1_v[p] = cap_if[p].cap1;
        assign cap2_v[p] = cap_if[p].cap2;

        rcr_port_store u_store
        (
            .i_clk_sys(i_clk_sys),
            .i_reset_n(i_reset_n),
            .bus(cap_if[p])
        );

        assign o_capability_freeze[p] = cap1_v[p][`RCR_BIT_FREEZE]; // R01
        assign o_frequency_training_request[p] = cap1_v[p][`RCR_BIT_FREQ]; // R07
        assign o_equalizer_training_request[p] = cap1_v[p][`RCR_BIT_EQ]; // R08
        assign o_remote_two_link_support[p] = cap1_v[p][`RCR_BIT_TWO_LINK]; // R09
        assign o_secondary_channel[p] = cap1_v[p][`RCR_BIT_CHANNEL]; // R10
        assign o_fast_control_channel_mode[p] = mode_code(cap1_v[p], cap2_v[p]); // R03 R11
    end

    always_comb
    begin
        rdata_d = `RCR_RDATA_IDLE;
        if (hit_cap1)
        begin
            rdata_d = cap1_v[port_sel]; // R06
        end
        else if (hit_cap2)
        begin
            rdata_d = {6'h00, cap2_v[port_sel]};
        end
    end

    // Read data is captured when the read is taken, so it shows the value before
    // any update landing in that same cycle.
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_q <= `RCR_RDATA_IDLE;
        end
        else if (i_reg_rd)
        begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            ack_q <= 1'b0;
        end
        else
        begin
            ack_q <= i_reg_rd || i_reg_wr;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mode0_q <= rcr_pkg::RCR_MODE_NORMAL;
            mode1_q <= rcr_pkg::RCR_MODE_NORMAL;
        end
        else
        begin
            mode0_q <= decode_mode(mode_code(cap1_v[0], cap2_v[0])); // R11
            mode1_q <= decode_mode(mode_code(cap1_v[1], cap2_v[1])); // R11
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_reg_ack = ack_q;
    assign o_mode_port0 = mode0_q;
    assign o_mode_port1 = mode1_q;

    chk_port1_write_route: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R06
        i_reg_wr && !i_reg_secondary && !i_secondary_address_enable && i_second_port_select
        && i_reg_addr == `RCR_ADDR_CAP1
        |=> cap1_v[1] == $past(i_reg_wdata) && ($stable(cap1_v[0]) || $past(i_auto_valid[0] && i_rx_lock[0])))
        else $error("Port1 select did not steer write to Port1");

    chk_select_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R12
        i_reg_wr && !i_reg_secondary && i_secondary_address_enable && i_second_port_select
        && i_reg_addr == `RCR_ADDR_CAP1
        |=> cap1_v[0] == $past(i_reg_wdata))
        else $error("Port select honoured while secondary address enabled");

    chk_read_route: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R06
        i_reg_rd && hit_cap1 |=> o_reg_rdata == $past(cap1_v[port_sel]))
        else $error("Read returned wrong port copy");

    chk_secondary_refused: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_reg_rd && i_reg_secondary && !i_secondary_address_enable
        |=> o_reg_rdata == `RCR_RDATA_IDLE)
        else $error("Disabled secondary address read returned data");

    chk_mode_low_bit: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R03
        $rose(cap1_v[0][`RCR_BIT_MODE_LO]) && cap2_v[0] == 2'h0
        |=> o_mode_port0 == rcr_pkg::RCR_MODE_GPIO1)
        else $error("Mode low bit not reflected in decoded mode");

    chk_mode_spi_fwd: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R11
        o_fast_control_channel_mode[0] == `RCR_CODE_SPI_FWD |=> o_mode_port0 == rcr_pkg::RCR_MODE_SPI_FWD)
        else $error("Forward SPI code not decoded");

    chk_reset_requests: assert property (@(posedge i_clk_sys) // R07 R08
        $rose(i_reset_n) |-> o_frequency_training_request == 2'h0
        && o_equalizer_training_request == 2'h0)
        else $error("Training requests not zero after reset");

    chk_unlocked_ignored: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R04
        i_auto_valid[0] && !i_rx_lock[0] && !i_reg_wr
        |=> $stable(cap1_v[0]) && $stable(cap2_v[0]))
        else $error("Capabilities loaded without receive lock");

    chk_training_from_channel: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R07 R08
        i_auto_valid[0] && i_rx_lock[0] && !o_capability_freeze[0] && !i_reg_wr
        |=> o_frequency_training_request[0] == $past(i_auto_cap1[0][`RCR_BIT_FREQ])
        && o_equalizer_training_request[0] == $past(i_auto_cap1[0][`RCR_BIT_EQ]))
        else $error("Training requests not taken from back channel");

    chk_port1_link_fields: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R09 R10
        i_auto_valid[1] && i_rx_lock[1] && !o_capability_freeze[1] && !i_reg_wr
        |=> o_remote_two_link_support[1] == $past(i_auto_cap1[1][`RCR_BIT_TWO_LINK])
        && o_secondary_channel[1] == $past(i_auto_cap1[1][`RCR_BIT_CHANNEL]))
        else $error("Port1 link fields not taken from back channel");

    chk_frozen_mode: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R01
        o_capability_freeze[0] && !i_reg_wr |=> $stable(o_fast_control_channel_mode[0]))
        else $error("Frozen mode changed without host write");

    chk_rdata_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !i_reg_rd |=> $stable(o_reg_rdata))
        else $error("Read data changed without a read");

    chk_ack_latency: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_reg_rd || i_reg_wr) |=> o_reg_ack ##1 (o_reg_ack == $past(i_reg_rd || i_reg_wr)))
        else $error("Access answer not one cycle after request");

endmodule

`default_nettype wire

// file: hdl/rcr_defs.svh
// Notes on behaviour
// R01: Freeze bit 7 stops automatic capability loading
// R02: Frozen values stay as software wrote them
// R03: Bit 6 is low bit of mode
// R04: After lock, back channel loads fields unless frozen
// R05: Software writing fields must also set freeze
// R06: Port one select steers access to Port1
// R07: Bit 5 requests frequency training, resets zero
// R08: Bit 4 requests equalizer training, resets zero
// R09: Bit 3 shows remote two-link support
// R10: Bit 2: zero primary, one secondary channel
// R11: Three-bit mode selects frame, GPIO or SPI
// R12: Secondary address enable makes port select ignored
// R13: Host write beats simultaneous automatic update
`ifndef RCR_DEFS_SVH
`define RCR_DEFS_SVH

`define RCR_ADDR_CAP1 8'h20
`define RCR_ADDR_CAP2 8'h21
`define RCR_CAP1_RESET 8'h00
`define RCR_CAP2_RESET 2'h0
`define RCR_RDATA_IDLE 8'h00

`define RCR_BIT_FREEZE 7
`define RCR_BIT_MODE_LO 6
`define RCR_BIT_FREQ 5
`define RCR_BIT_EQ 4
`define RCR_BIT_TWO_LINK 3
`define RCR_BIT_CHANNEL 2
`define RCR_AUTO_MSB 6
`define RCR_CAP2_MSB 1

`define RCR_CODE_NORMAL 3'h0
`define RCR_CODE_GPIO1 3'h1
`define RCR_CODE_GPIO2 3'h2
`define RCR_CODE_GPIO4 3'h3
`define RCR_CODE_SPI_FWD 3'h6
`define RCR_CODE_SPI_REV 3'h7

`define RCR_PORT0 1'h0
`define RCR_PORT1 1'h1

`endif

// file: hdl/rcr_pkg.sv
package rcr_pkg;

    typedef enum logic [2:0]
    {
        RCR_MODE_NORMAL,
        RCR_MODE_GPIO1,
        RCR_MODE_GPIO2,
        RCR_MODE_GPIO4,
        RCR_MODE_SPI_FWD,
        RCR_MODE_SPI_REV,
        RCR_MODE_RESERVED
    } rcr_mode_t;

endpackage

// file: hdl/rcr_cap_if.sv
`timescale 1ns/100ps
`default_nettype none

interface rcr_cap_if;
    logic host_wr1;
    logic host_wr2;
    logic [7:0] wdata;
    logic auto_ld;
    logic [6:0] auto_cap1;
    logic [1:0] auto_cap2;
    logic [7:0] cap1;
    logic [1:0] cap2;

    modport store
    (
        input host_wr1,
        input host_wr2,
        input wdata,
        input auto_ld,
        input auto_cap1,
        input auto_cap2,
        output cap1,
        output cap2
    );

    modport ctrl
    (
        output host_wr1,
        output host_wr2,
        output wdata,
        output auto_ld,
        output auto_cap1,
        output auto_cap2,
        input cap1,
        input cap2
    );
endinterface

`default_nettype wire

// file: hdl/rcr_port_store.sv
`timescale 1ns/100ps
`default_nettype none
`include "rcr_defs.svh"

module rcr_port_store
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    rcr_cap_if.store bus
);

    logic [7:0] cap1_q;
    logic [1:0] cap2_q;
    logic frozen;

    assign frozen = cap1_q[`RCR_BIT_FREEZE];

    // Host write first, so a write that sets freeze is never undone by a racing update
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cap1_q <= `RCR_CAP1_RESET; // R07 R08
        end
        else if (bus.host_wr1)
        begin
            cap1_q <= bus.wdata; // R13
        end
        else if (bus.auto_ld && !frozen) // R01 R02 R04
        begin
            cap1_q[`RCR_AUTO_MSB:0] <= bus.auto_cap1; // R03 R09 R10
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            cap2_q <= `RCR_CAP2_RESET;
        end
        else if (bus.host_wr2)
        begin
            cap2_q <= bus.wdata[`RCR_CAP2_MSB:0]; // R13
        end
        else if (bus.auto_ld && !frozen) // R01 R02
        begin
            cap2_q <= bus.auto_cap2; // R11
        end
    end

    assign bus.cap1 = cap1_q;
    assign bus.cap2 = cap2_q;

    chk_frozen_cap1_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R02
        frozen && !bus.host_wr1 |=> $stable(cap1_q))
        else $error("Frozen capabilities changed without host write");

    chk_frozen_cap2_hold: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R01
        frozen && bus.auto_ld && !bus.host_wr2 |=> cap2_q == $past(cap2_q))
        else $error("Frozen mode bits loaded by back channel");

    chk_auto_load_taken: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R04
        bus.auto_ld && !frozen && !bus.host_wr1 |=> cap1_q[`RCR_AUTO_MSB:0] == $past(bus.auto_cap1))
        else $error("Automatic capability update not taken");

    chk_host_write_wins: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // R13
        bus.host_wr1 && bus.auto_ld |=> cap1_q == $past(bus.wdata))
        else $error("Automatic update overrode host write");

endmodule

`default_nettype wire

// file: hdl/rcr_unused_note.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// file: test/rcr_bc_model.sv
`timescale 1ns/100ps
`default_nettype none

module rcr_bc_model
(
    input wire logic i_send,
    input wire logic i_port,
    input wire logic [8:0] i_caps,
    output logic [1:0] o_valid,
    output logic [1:0][6:0] o_cap1,
    output logic [1:0][1:0] o_cap2
);
    // Outside an update the lines show the inverse, so a stale value is never mistaken for news
    always_comb
    begin
        for (int p = 0; p < 2; p++)
        begin
            o_valid[p] = i_send && (i_port == p[0]);
            o_cap1[p] = o_valid[p] ? i_caps[6:0] : ~i_caps[6:0];
            o_cap2[p] = o_valid[p] ? i_caps[8:7] : ~i_caps[8:7];
        end
    end
endmodule

`default_nettype wire

// file: test/remote_capability_register_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
    $display("Error at %0t: got %0h want %0h", $time, a, b); end end

module remote_capability_register_tb_top;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, sec = 0, psel = 0, sen = 0, send = 0, bport = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic [1:0] lock = 2'h0, av, frz, frq, eqr, two, chn;
    logic [8:0] caps = 9'h000, c, d;
    logic [1:0][6:0] ac1;
    logic [1:0][1:0] ac2;
    logic [1:0][2:0] mode;
    logic ack;
    rcr_pkg::rcr_mode_t m0, m1;
    rcr_pkg::rcr_mode_t tbl [8] = '{rcr_pkg::RCR_MODE_NORMAL, rcr_pkg::RCR_MODE_GPIO1, rcr_pkg::RCR_MODE_GPIO2,
        rcr_pkg::RCR_MODE_GPIO4, rcr_pkg::RCR_MODE_RESERVED, rcr_pkg::RCR_MODE_RESERVED,
        rcr_pkg::RCR_MODE_SPI_FWD, rcr_pkg::RCR_MODE_SPI_REV};
    logic [8:0] q [$];
    int n_errors = 0, n_checks = 0, seed = 36976;

    initial forever #10 clk = ~clk;

    remote_capability_register i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wd), .i_reg_secondary(sec), .i_second_port_select(psel),
        .i_secondary_address_enable(sen), .i_rx_lock(lock), .i_auto_valid(av), .i_auto_cap1(ac1),
        .i_auto_cap2(ac2), .o_reg_rdata(rdata), .o_reg_ack(ack), .o_capability_freeze(frz),
        .o_frequency_training_request(frq), .o_equalizer_training_request(eqr),
        .o_remote_two_link_support(two), .o_secondary_channel(chn), .o_fast_control_channel_mode(mode),
        .o_mode_port0(m0), .o_mode_port1(m1));

    rcr_bc_model i_bc (.i_send(send), .i_port(bport), .i_caps(caps), .o_valid(av), .o_cap1(ac1), .o_cap2(ac2));

    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Bit 8 of a note marks a read whose data is compared when the answer shows
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] dat);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wd = dat;
        q.push_back({!w, dat});
        @(negedge clk);
        wr = 0;
        rd = 0;
    endtask

    task automatic auto_ld(input logic p, input logic [8:0] v);
        @(negedge clk);
        send = 1;
        bport = p;
        caps = v;
        @(negedge clk);
        send = 0;
    endtask

    always @(negedge clk)
    begin
        if (ack === 1'b1)
        begin
            if (q.size() == 0)
                `CHK(1'b0, 1'b1)
            else if (q[0][8])
                `CHK(rdata, q[0][7:0])
            void'(q.pop_front());
        end
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        stop_test();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1;
        acc(0, 8'h20, 8'h00);
        acc(0, 8'h21, 8'h00);
        $display("Test reset done");
        lock = 2'h3;
        c = 9'($random(seed));
        auto_ld(0, c);
        `CHK(mode[0], c[8:6])
        `CHK(two[0], c[3])
        `CHK(chn[0], c[2])
        acc(0, 8'h20, {1'b0, c[6:0]});
        acc(0, 8'h21, {6'h00, c[8:7]});
        lock = 2'h2;
        auto_ld(0, ~c);
        acc(0, 8'h20, {1'b0, c[6:0]});
        lock = 2'h3;
        $display("Test auto load done");
        d = 9'($random(seed));
        acc(1, 8'h20, {1'b1, d[6:0]});
        auto_ld(0, ~d);
        `CHK(frz[0], 1'b1)
        acc(0, 8'h20, {1'b1, d[6:0]});
        acc(0, 8'h21, {6'h00, c[8:7]});
        $display("Test freeze done");
        psel = 1;
        acc(1, 8'h20, 8'h30);
        `CHK(frq[1], 1'b1)
        `CHK(eqr[1], 1'b1)
        acc(0, 8'h20, 8'h30);
        sen = 1;
        acc(0, 8'h20, {1'b1, d[6:0]});
        sec = 1;
        acc(0, 8'h20, 8'h30);
        sec = 0;
        sen = 0;
        psel = 0;
        acc(0, 8'h20, {1'b1, d[6:0]});
        $display("Test port select done");
        sec = 1;
        acc(0, 8'h20, 8'h00);
        sec = 0;
        auto_ld(1, d);
        `CHK(mode[1], d[8:6])
        `CHK(two[1], d[3])
        `CHK(chn[1], d[2])
        `CHK(frz[1], 1'b0)
        `CHK(frq[0], d[5])
        @(negedge clk);
        `CHK(m1, tbl[d[8:6]])
        $display("Test port one load done");
        acc(1, 8'h20, 8'h00);
        @(negedge clk);
        wr = 1;
        addr = 8'h20;
        wd = 8'h15;
        q.push_back(9'h015);
        send = 1;
        bport = 0;
        caps = 9'h06a;
        @(negedge clk);
        wr = 0;
        send = 0;
        acc(0, 8'h20, 8'h15);
        $display("Test collision done");
        for (int k = 0; k < 8; k++)
        begin
            acc(1, 8'h21, {6'h00, 2'(k >> 1)});
            acc(1, 8'h20, {1'b1, k[0], 6'h00});
            @(negedge clk);
            `CHK(m0, tbl[k])
        end
        $display("Test modes done");
        repeat (2) @(negedge clk);
        stop_test();
    end
endmodule

`default_nettype wire
